// ==== core/mcc_pkg.sv ====
// Constants, types and register map of the master clock controller.
// Assumes a 40 MHz system clock and an 8-bit register file on classic Wishbone.
`default_nettype none
package mcc_pkg;
  // Timing, in the system clock domain
  localparam int unsigned SYS_PERIOD_NS = 25;    // System clock period
  localparam int unsigned FAIL_TIME_NS  = 2000;  // Longest gap in external edges
  localparam int unsigned WAKE_TIME_NS  = 1000;  // Regulator restart delay
  localparam logic [7:0]  FAIL_CYC = 8'(FAIL_TIME_NS / SYS_PERIOD_NS);
  localparam logic [7:0]  WAKE_CYC = 8'((WAKE_TIME_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS);

  // Source codes
  localparam logic [1:0] SRC_EXT_XTAL = 2'h0;  // ext_fast_osc, crystal
  localparam logic [1:0] SRC_EXT_USER = 2'h1;  // ext_fast_osc, user clock
  localparam logic [1:0] SRC_INT_FAST = 2'h2;  // int_fast_rc
  localparam logic [1:0] SRC_INT_SLOW = 2'h3;  // int_slow_rc

  // Register byte offsets
  localparam logic [7:0] OFS_SWITCH  = 8'h00;  // Target source, switch request
  localparam logic [7:0] OFS_STATUS  = 8'h04;  // Current source, busy, fail
  localparam logic [7:0] OFS_DIVIDER = 8'h08;  // Prescaler exponent
  localparam logic [7:0] OFS_GATE1   = 8'h0C;  // peripheral_clock_gate_1
  localparam logic [7:0] OFS_GATE2   = 8'h10;  // peripheral_clock_gate_2
  localparam logic [7:0] OFS_MONITOR = 8'h14;  // clock_fail_monitor control
  localparam logic [7:0] OFS_CLKOUT  = 8'h18;  // clock_out_function control
  localparam logic [7:0] OFS_POWER   = 8'h1C;  // Low-power options

  // Field positions
  localparam int unsigned SW_GO_BIT   = 2;  // Switch register: request
  localparam int unsigned ST_BUSY_BIT = 2;  // Status: switch pending
  localparam int unsigned ST_FAIL_BIT = 3;  // Status: clock failure seen
  localparam int unsigned MON_EN_BIT  = 0;  // Monitor enable
  localparam int unsigned MON_IE_BIT  = 1;  // Monitor interrupt enable
  localparam int unsigned MON_FL_BIT  = 2;  // Monitor fail flag (read)
  localparam int unsigned CO_EN_BIT   = 0;  // Clock output enable
  localparam int unsigned PW_REGOFF_BIT = 0;  // Regulator off in active-halt

  // Gate register bit positions
  localparam int unsigned G1_TIMER_ONE  = 7;  // gate_timer_one
  localparam int unsigned G1_TIMER_FIVE = 6;  // gate_timer_five
  localparam int unsigned G1_TIMER_SIX  = 4;  // gate_timer_six
  localparam int unsigned G1_LIN_UART   = 3;  // gate_lin_uart
  localparam int unsigned G1_SPI        = 1;  // gate_spi
  localparam int unsigned G1_I2C        = 0;  // gate_i2c
  localparam int unsigned G2_ADC        = 3;  // gate_adc
  localparam int unsigned G2_AUTO_WAKE  = 2;  // gate_auto_wakeup
  localparam logic [7:0]  GATE1_MASK = 8'hDB;  // Implemented gate 1 bits
  localparam logic [7:0]  GATE2_MASK = 8'h0C;  // Implemented gate 2 bits

  // Reset values
  localparam logic [1:0] RST_SRC   = SRC_INT_FAST;
  localparam logic [2:0] RST_DIV   = 3'h3;   // Divide by eight
  localparam logic [7:0] RST_GATE1 = 8'hDB;
  localparam logic [7:0] RST_GATE2 = 8'h0C;
  localparam logic [2:0] CO_SEL_MASTER = 3'h4;  // Clock out: divided master

  // Low-power modes
  typedef enum logic [2:0] {PM_RUN, PM_WAIT, PM_AHALT, PM_HALT, PM_WAKE} mcc_pmode_t;

  // Classic Wishbone request and answer
  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } mcc_wb_req_t;

  typedef struct packed {
    logic        ack;
    logic [31:0] dat;
  } mcc_wb_rsp_t;
endpackage : mcc_pkg
`default_nettype wire

// ==== core/mcc_master_clock_controller.sv ====
// Master clock controller: source select, prescaler, fallback, gating, clock out.
// Assumes source clocks and ready flags arrive as pins sampled by the 40 MHz clock.
//
// Contract
// - Master clock from any of four sources.
// - Switch only once new source ready, glitch-free.
// - After reset run fast RC divided by eight.
// - Programmable prescaler divides selected source.
// - Monitor falls back to fast RC/8 on failure.
// - Stop CPU, peripheral and memory clocks separately.
// - Gate 1 bits: timers, UART, SPI, I2C.
// - Gate 2 bits: ADC and auto-wakeup.
// - Drive configurable clock copy on output pin.
// - Wait stops CPU only; any interrupt wakes.
// - Active-halt stops all but the auto-wakeup clock; auto-wakeup or external wakes. Master tick and clock out keep running here.
// - Active-halt regulator on or off, slower wake.
// - Halt stops all, regulator off, external wake. Master tick and clock out keep running here.
`default_nettype none
module mcc_master_clock_controller (
  input  wire logic                 i_sys_clk,     // 40 MHz system clock
  input  wire logic                 i_reset_n,     // Asynchronous reset, low
  input  wire mcc_pkg::mcc_wb_req_t i_wb,          // Wishbone request
  output var  mcc_pkg::mcc_wb_rsp_t o_wb,          // Wishbone answer
  input  wire logic [3:0]           i_src_clk,     // Source clocks, by code
  input  wire logic [3:0]           i_src_ready,   // Source ready flags
  input  wire logic                 i_wait_req,    // CPU enters wait
  input  wire logic                 i_ahalt_req,   // CPU enters active-halt
  input  wire logic                 i_halt_req,    // CPU enters halt
  input  wire logic                 i_irq_wake,    // Any internal interrupt
  input  wire logic                 i_awu_wake,    // Auto-wakeup interrupt
  input  wire logic                 i_ext_wake,    // External event pin
  output logic                      o_master_tick, // Master clock enable
  output logic                      o_cpu_tick,    // CPU clock enable
  output logic                      o_mem_tick,    // Memory clock enable
  output logic [7:0]                o_gate1_tick,  // Peripheral enables, gate 1
  output logic [7:0]                o_gate2_tick,  // Peripheral enables, gate 2
  output logic                      o_clk_out,     // clock_out_pin level
  output logic                      o_main_reg_on, // Main regulator enable
  output logic                      o_fail_irq     // Clock failure interrupt
);
  import mcc_pkg::*;

  // Whole state of the block
  typedef struct packed {
    logic [3:0]  s1;       // Source sync, first stage
    logic [3:0]  s2;       // Source sync, second stage
    logic [3:0]  s3;       // Edge history
    logic [3:0]  r1;       // Ready sync, first stage
    logic [3:0]  r2;       // Ready sync, second stage
    logic        e1;       // External wake sync, first stage
    logic        e2;       // External wake sync, second stage
    logic        ack;      // Bus acknowledge
    logic [7:0]  rdat;     // Bus read data
    logic [1:0]  target;   // Requested source
    logic        busy;     // Switch pending
    logic [1:0]  cur;      // Source in use
    logic [2:0]  div;      // Prescaler exponent
    logic [7:0]  cnt;      // Prescaler edge count
    logic [7:0]  gate1;    // peripheral_clock_gate_1
    logic [7:0]  gate2;    // peripheral_clock_gate_2
    logic        mon_en;   // Monitor enabled
    logic        mon_ie;   // Monitor interrupt enabled
    logic        fail;     // Sticky failure flag
    logic [7:0]  fcnt;     // Cycles since last external edge
    logic        co_en;    // Clock output enabled
    logic [2:0]  co_sel;   // Clock output selection
    logic        reg_off;  // Regulator off in active-halt
    mcc_pmode_t  pmode;    // Low-power mode
    logic [7:0]  wcnt;     // Wake delay count
    logic        tick;     // Master tick
    logic        cpu_tick; // CPU tick
    logic        mem_tick; // Memory tick
    logic [7:0]  g1_tick;  // Gate 1 ticks
    logic [7:0]  g2_tick;  // Gate 2 ticks
    logic        clk_out;  // Pin level
    logic        reg_on;   // Regulator enable
    logic        irq;      // Failure interrupt
  } mcc_state_t;

  mcc_state_t q;           // Registered state
  mcc_state_t n;           // Next state
  logic [3:0] src_edge;    // Rising edges of synced sources
  logic [7:0] lim;         // Prescaler wrap count
  logic [7:0] rd;          // Read mux
  logic       wr;          // Write strobe
  logic       run_clk;     // Peripherals clocked
  logic [7:0] word_ofs;    // Word-aligned byte offset

  // Next-state logic: bus, switching, prescaler, monitor, power modes
  always_comb
  begin
    n        = q;
    src_edge = q.s2 & ~q.s3;
    lim      = 8'((16'h0001 << q.div) - 16'h0001);
    word_ofs = {i_wb.adr[7:2], 2'b00};
    rd       = 8'h00;
    run_clk  = 1'b0;

    // Synchronisers: first stage feeds only the second
    n.s1 = i_src_clk;
    n.s2 = q.s1;
    n.s3 = q.s2;
    n.r1 = i_src_ready;
    n.r2 = q.r1;
    n.e1 = i_ext_wake;
    n.e2 = q.e1;

    // Bus answer in the cycle after the strobe, dropped one cycle later
    n.ack = i_wb.cyc & i_wb.stb & ~q.ack;
    wr    = n.ack & i_wb.we & i_wb.sel[0];

    // Read mux; unmapped words read as zero
    if (word_ofs == OFS_SWITCH)
      rd = {5'h00, q.busy, q.target};
    else if (word_ofs == OFS_STATUS)
      rd = {4'h0, q.fail, q.busy, q.cur};
    else if (word_ofs == OFS_DIVIDER)
      rd = {5'h00, q.div};
    else if (word_ofs == OFS_GATE1)
      rd = q.gate1 & GATE1_MASK;
    else if (word_ofs == OFS_GATE2)
      rd = q.gate2 & GATE2_MASK;
    else if (word_ofs == OFS_MONITOR)
      rd = {5'h00, q.fail, q.mon_ie, q.mon_en};
    else if (word_ofs == OFS_CLKOUT)
      rd = {4'h0, q.co_sel, q.co_en};
    else if (word_ofs == OFS_POWER)
      rd = {7'h00, q.reg_off};
    n.rdat = rd;

    // Register writes; unmapped writes are dropped
    if (wr)
    begin
      if (word_ofs == OFS_SWITCH)
      begin
        if (i_wb.dat[SW_GO_BIT])
        begin
          n.target = i_wb.dat[1:0];
          n.busy   = 1'b1;
          n.fail   = 1'b0;
        end
      end
      else if (word_ofs == OFS_DIVIDER)
        n.div = i_wb.dat[2:0];
      else if (word_ofs == OFS_GATE1)
        n.gate1 = i_wb.dat[7:0] & GATE1_MASK;
      else if (word_ofs == OFS_GATE2)
        n.gate2 = i_wb.dat[7:0] & GATE2_MASK;
      else if (word_ofs == OFS_MONITOR)
      begin
        n.mon_en = i_wb.dat[MON_EN_BIT];
        n.mon_ie = i_wb.dat[MON_IE_BIT];
      end
      else if (word_ofs == OFS_CLKOUT)
      begin
        n.co_en  = i_wb.dat[CO_EN_BIT];
        n.co_sel = i_wb.dat[3:1];
      end
      else if (word_ofs == OFS_POWER)
        n.reg_off = i_wb.dat[PW_REGOFF_BIT];
    end

    // Prescaler counts edges of the source in use
    // Edges are seen through the synchroniser, so a source must stay below
    // half the system clock or edges are lost
    n.tick = 1'b0;
    if (src_edge[q.cur])
    begin
      if (q.cnt >= lim)
      begin
        n.cnt  = 8'h00;
        n.tick = 1'b1;
      end
      else
        n.cnt = q.cnt + 8'h01;
    end

    // Switch only between periods, so no short pulse is ever produced
    if (q.busy && q.r2[q.target] && (q.cnt == 8'h00) && !src_edge[q.cur])
    begin
      n.cur  = q.target;
      n.busy = 1'b0;
      n.cnt  = 8'h00;
    end

    // Failure monitor watches an external source in use
    if (q.mon_en && !q.cur[1])
    begin
      if (src_edge[q.cur])
        n.fcnt = 8'h00;
      else if (q.fcnt >= FAIL_CYC - 8'h01)
      begin
        // Fallback wins over a same-cycle software switch
        n.fail = 1'b1;
        n.cur  = SRC_INT_FAST;
        n.div  = RST_DIV;
        n.busy = 1'b0;
        n.cnt  = 8'h00;
        n.fcnt = 8'h00;
      end
      else
        n.fcnt = q.fcnt + 8'h01;
    end
    else
      n.fcnt = 8'h00;
    n.irq = n.fail & n.mon_ie;

    // Low-power mode sequencing
    unique case (q.pmode)
      PM_RUN:
      begin
        if (i_halt_req)
          n.pmode = PM_HALT;
        else if (i_ahalt_req)
          n.pmode = PM_AHALT;
        else if (i_wait_req)
          n.pmode = PM_WAIT;
      end
      PM_WAIT:
      begin
        if (i_irq_wake || i_awu_wake || q.e2)
          n.pmode = PM_RUN;
      end
      PM_AHALT:
      begin
        // Regulator off costs a restart delay
        if (i_awu_wake || q.e2)
        begin
          n.pmode = q.reg_off ? PM_WAKE : PM_RUN;
          n.wcnt  = 8'h00;
        end
      end
      PM_HALT:
      begin
        if (q.e2)
        begin
          n.pmode = PM_WAKE;
          n.wcnt  = 8'h00;
        end
      end
      PM_WAKE:
      begin
        if (q.wcnt >= WAKE_CYC - 8'h01)
          n.pmode = PM_RUN;
        else
          n.wcnt = q.wcnt + 8'h01;
      end
      default:
        n.pmode = PM_RUN;
    endcase

    // Clock enables follow the mode of this cycle
    run_clk    = (q.pmode == PM_RUN) || (q.pmode == PM_WAIT);
    n.cpu_tick = n.tick && (q.pmode == PM_RUN);
    n.mem_tick = n.tick && run_clk;
    n.g1_tick  = (n.tick && run_clk) ? (q.gate1 & GATE1_MASK) : 8'h00;
    n.g2_tick  = (n.tick && run_clk) ? (q.gate2 & GATE2_MASK) : 8'h00;
    // Auto-wakeup keeps its clock in active-halt so it can wake the chip
    if (n.tick && (q.pmode == PM_AHALT))
      n.g2_tick[G2_AUTO_WAKE] = q.gate2[G2_AUTO_WAKE];
    n.reg_on = !((q.pmode == PM_HALT) || ((q.pmode == PM_AHALT) && q.reg_off));

    // Clock output: raw synced source or halved master
    if (!q.co_en)
      n.clk_out = 1'b0;
    else if (q.co_sel[2])
      n.clk_out = n.tick ? ~q.clk_out : q.clk_out;
    else
      n.clk_out = q.s2[q.co_sel[1:0]];
  end

  // State register
  // Reset loads constants only, so any reset restarts from fast RC / 8
  always_ff @(posedge i_sys_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      q        <= '0;
      q.target <= RST_SRC;
      q.cur    <= RST_SRC;
      q.div    <= RST_DIV;
      q.gate1  <= RST_GATE1;
      q.gate2  <= RST_GATE2;
      q.pmode  <= PM_RUN;
      q.reg_on <= 1'b1;
    end
    else
      q <= n;
  end

  // Outputs straight from the state register
  assign o_wb.ack      = q.ack;
  assign o_wb.dat      = {24'h000000, q.rdat};
  assign o_master_tick = q.tick;
  assign o_cpu_tick    = q.cpu_tick;
  assign o_mem_tick    = q.mem_tick;
  assign o_gate1_tick  = q.g1_tick;
  assign o_gate2_tick  = q.g2_tick;
  assign o_clk_out     = q.clk_out;
  assign o_main_reg_on = q.reg_on;
  assign o_fail_irq    = q.irq;
endmodule : mcc_master_clock_controller
`default_nettype wire

// ==== tb/mcc_checker_sva.sv ====
// Port checker of the master clock controller, bound to its top module.
// Assumes one clock domain and the registered outputs the module declares.
`default_nettype none
module mcc_checker_sva (
  input wire logic                 i_sys_clk,     // System clock
  input wire logic                 i_reset_n,     // Asynchronous reset, low
  input wire mcc_pkg::mcc_wb_req_t i_wb,          // Bus request
  input wire mcc_pkg::mcc_wb_rsp_t o_wb,          // Bus answer
  input wire logic                 o_master_tick, // Master enable
  input wire logic                 o_cpu_tick,    // CPU enable
  input wire logic                 o_mem_tick,    // Memory enable
  input wire logic [7:0]           o_gate1_tick,  // Gate 1 enables
  input wire logic [7:0]           o_gate2_tick,  // Gate 2 enables
  input wire logic                 o_main_reg_on  // Regulator enable
);
  timeunit 1ns;
  timeprecision 100ps;
  import mcc_pkg::*;
  // All checks share the system clock; reset silences them
  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (!i_reset_n);

  // A fresh request is answered one cycle later, and only once
  AST_ACK_NEXT: assert property (i_wb.cyc && i_wb.stb && !o_wb.ack |=> o_wb.ack)
    else $error("request not answered after one cycle");
  AST_ACK_PULSE: assert property (o_wb.ack |=> !o_wb.ack)
    else $error("answer held longer than one cycle");
  AST_DAT_HIGH: assert property (o_wb.ack |-> o_wb.dat[31:8] == 24'h0)
    else $error("upper read data not zero");
  // Pulses closer than a source period would be a runt clock
  AST_NO_RUNT: assert property (o_master_tick |=> !o_master_tick)
    else $error("master ticks on adjacent cycles");
  AST_CPU_MEM: assert property (o_cpu_tick |-> o_mem_tick && o_master_tick)
    else $error("cpu tick without memory and master tick");
  AST_MEM_MASTER: assert property (o_mem_tick |-> o_master_tick)
    else $error("memory tick without master tick");
  AST_GATE1_RSV: assert property (o_gate1_tick != 8'h00 |->
    o_master_tick && (o_gate1_tick & 8'h24) == 8'h00)
    else $error("bad gate 1 tick");
  AST_GATE2_RSV: assert property (o_gate2_tick != 8'h00 |->
    o_master_tick && (o_gate2_tick & 8'hF3) == 8'h00)
    else $error("bad gate 2 tick");
  // With the regulator off neither the CPU nor any gate 1 peripheral may tick
  AST_REG_OFF: assert property (!o_main_reg_on |-> !o_cpu_tick && o_gate1_tick == 8'h00)
    else $error("clocks running with regulator off");
endmodule : mcc_checker_sva
bind mcc_master_clock_controller mcc_checker_sva u_chk (.i_sys_clk, .i_reset_n, .i_wb, .o_wb,
  .o_master_tick, .o_cpu_tick, .o_mem_tick, .o_gate1_tick, .o_gate2_tick, .o_main_reg_on);
`default_nettype wire

// ==== tb/master_clock_controller_test.sv ====
// Self-checking bench of the master clock controller.
// Assumes the package and design from core/ are compiled first.
`default_nettype none
`define CK(n, e, s) begin comparisons++; if ((s) !== (e)) begin n_mismatch++; \
  $display("unexpected %s exp %0h got %0h", n, e, s); end end
module master_clock_controller_test;
  timeunit 1ns;
  timeprecision 100ps;
  import mcc_pkg::*;
  typedef struct packed {logic w; logic [7:0] a; logic [7:0] d; logic [7:0] e;} mcc_row_t;
  logic        i_sys_clk = 1'b0;         // 40 MHz clock
  logic        i_reset_n = 1'b0;         // Reset held from time zero
  mcc_wb_req_t i_wb = '0;                // Bus request
  mcc_wb_rsp_t o_wb;                     // Bus answer
  logic [3:0]  i_src_clk = 4'h0;         // Source clocks
  logic [3:0]  i_src_ready = 4'hE;       // Crystal not ready yet
  logic        i_wait_req = 1'b0, i_ahalt_req = 1'b0, i_halt_req = 1'b0;
  logic        i_irq_wake = 1'b0, i_awu_wake = 1'b0, i_ext_wake = 1'b0;
  logic        o_master_tick, o_cpu_tick, o_mem_tick, o_clk_out, o_main_reg_on, o_fail_irq;
  logic [7:0]  o_gate1_tick, o_gate2_tick, g1, g2, rd;  // Outputs, gate sums, read data
  logic [2:0]  sc = 3'h0;                // Source half period counter
  logic [3:0]  run = 4'hF;               // Oscillators running
  int          n_mismatch = 0, comparisons = 0;
  integer      nm, nc, ne, nt;           // Window counts; four-state so unknowns show
  // Reads then write-readback pairs, reserved bits and an unmapped word among them
  mcc_row_t rows [12] = '{'{0, OFS_GATE1, 0, 8'hDB}, '{0, OFS_GATE2, 0, 8'h0C},
    '{0, OFS_DIVIDER, 0, 8'h03}, '{0, OFS_STATUS, 0, 8'h02}, '{1, OFS_GATE1, 8'hFF, 8'hDB},
    '{1, OFS_GATE1, 8'h24, 8'h00}, '{1, OFS_GATE2, 8'hFF, 8'h0C}, '{1, OFS_GATE2, 8'hF3, 8'h00},
    '{1, 8'h3C, 8'hFF, 8'h00}, '{1, OFS_DIVIDER, 8'h07, 8'h07}, '{1, OFS_MONITOR, 8'h03, 8'h03},
    '{1, OFS_POWER, 8'h01, 8'h01}};

  mcc_master_clock_controller u_dut (.i_sys_clk, .i_reset_n, .i_wb, .o_wb, .i_src_clk,
    .i_src_ready, .i_wait_req, .i_ahalt_req, .i_halt_req, .i_irq_wake, .i_awu_wake,
    .i_ext_wake, .o_master_tick, .o_cpu_tick, .o_mem_tick, .o_gate1_tick, .o_gate2_tick,
    .o_clk_out, .o_main_reg_on, .o_fail_irq);

  initial
  begin
    forever #12.5 i_sys_clk = ~i_sys_clk;
  end
  // Sources at 2.5 MHz; a stopped one freezes, as a failed crystal would
  always @(posedge i_sys_clk)
  begin
    sc <= sc + 3'h1;
    if (sc == 3'h7)
      i_src_clk <= i_src_clk ^ run;
  end

  task automatic complete_run();
    $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : complete_run

  // One classic cycle; the request stands until ack is sampled
  task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge i_sys_clk);
    i_wb <= '{1'b1, 1'b1, w, a, 4'hF, {24'h0, d}};
    // No cycle count assumed; only the watchdog ends a lost answer
    while (o_wb.ack !== 1'b1)
      @(posedge i_sys_clk);
    rd = o_wb.dat[7:0];
    i_wb <= '0;
  endtask : wb

  // One-cycle pulse on wait, active-halt, halt, interrupt, auto-wakeup
  task automatic pulse(input logic [4:0] k);
    @(posedge i_sys_clk);
    {i_wait_req, i_ahalt_req, i_halt_req, i_irq_wake, i_awu_wake} <= k;
    @(posedge i_sys_clk);
    {i_wait_req, i_ahalt_req, i_halt_req, i_irq_wake, i_awu_wake} <= 5'h00;
    repeat (3) @(posedge i_sys_clk);
  endtask : pulse

  // Counts ticks and clock out toggles over a window
  task automatic meas(input int n);
    logic c;
    nm = 0;
    nc = 0;
    ne = 0;
    nt = 0;
    g1 = 8'h00;
    g2 = 8'h00;
    c = o_clk_out;
    repeat (n)
    begin
      @(posedge i_sys_clk);
      nm += o_master_tick;
      nc += o_cpu_tick;
      ne += o_mem_tick;
      nt += (o_clk_out != c);
      c = o_clk_out;
      g1 |= o_gate1_tick;
      g2 |= o_gate2_tick;
    end
  endtask : meas

  initial
  begin
    #(25 * 20000);
    n_mismatch++;
    complete_run();
  end

  initial
  begin
    repeat (5) @(posedge i_sys_clk);
    `CK("reset tick", 1'b0, o_master_tick)
    `CK("reset regulator", 1'b1, o_main_reg_on)
    i_reset_n <= 1'b1;
    meas(1024);
    `CK("ticks fast rc div 8", 1'b1, nm inside {[7:9]})
    for (int i = 0; i < 12; i++)
    begin
      if (rows[i].w)
        wb(1, rows[i].a, rows[i].d);
      wb(0, rows[i].a, 8'h00);
      `CK("register", rows[i].e, rd)
    end
    wb(1, OFS_DIVIDER, 8'h00);
    wb(1, OFS_GATE1, 8'h80);
    wb(1, OFS_CLKOUT, 8'h09);
    meas(1024);
    `CK("ticks div 1", 1'b1, nm inside {[63:65]})
    `CK("cpu ticks", nm, nc)
    `CK("gate 1 ticks", 8'h80, g1)
    `CK("gate 2 ticks", 8'h00, g2)
    `CK("clock out toggles", 1'b1, nt inside {[nm - 1:nm + 1]})
    pulse(5'h10);
    meas(256);
    `CK("wait cpu", 0, nc)
    `CK("wait peripherals", 8'h80, g1)
    pulse(5'h02);
    meas(256);
    `CK("wait woken", 1'b1, nc > 0)
    wb(1, OFS_GATE2, 8'h04);
    pulse(5'h08);
    meas(256);
    `CK("active halt cpu", 0, nc + ne)
    `CK("active halt gate 1", 8'h00, g1)
    `CK("active halt wakeup", 8'h04, g2)
    `CK("regulator off", 1'b0, o_main_reg_on)
    pulse(5'h01);
    repeat (60) @(posedge i_sys_clk);
    meas(256);
    `CK("active halt woken", 1'b1, nc > 0 && o_main_reg_on)
    pulse(5'h04);
    pulse(5'h01);
    meas(256);
    `CK("halt ignores timer", 0, nc + ne)
    `CK("halt regulator", 1'b0, o_main_reg_on)
    i_ext_wake <= 1'b1;
    repeat (4) @(posedge i_sys_clk);
    i_ext_wake <= 1'b0;
    repeat (60) @(posedge i_sys_clk);
    meas(256);
    `CK("halt woken", 1'b1, nc > 0 && o_main_reg_on)
    wb(1, OFS_SWITCH, 8'h04);
    repeat (50) @(posedge i_sys_clk);
    wb(0, OFS_STATUS, 8'h00);
    `CK("switch pending", 8'h06, rd)
    i_src_ready <= 4'hF;
    repeat (50) @(posedge i_sys_clk);
    wb(0, OFS_STATUS, 8'h00);
    `CK("switch done", 8'h00, rd)
    run <= 4'hE;
    repeat (200) @(posedge i_sys_clk);
    wb(0, OFS_STATUS, 8'h00);
    `CK("fallback status", 8'h0A, rd)
    wb(0, OFS_DIVIDER, 8'h00);
    `CK("fallback divider", 8'h03, rd)
    `CK("fail interrupt", 1'b1, o_fail_irq)
    run <= 4'hF;
    repeat (100) @(posedge i_sys_clk);
    wb(0, OFS_MONITOR, 8'h00);
    `CK("fail kept", 8'h07, rd)
    wb(1, OFS_SWITCH, 8'h06);
    // At divide by eight the switch waits up to eight source periods
    repeat (150) @(posedge i_sys_clk);
    wb(0, OFS_STATUS, 8'h00);
    `CK("fail cleared", 8'h02, rd)
    `CK("interrupt cleared", 1'b0, o_fail_irq)
    wb(1, OFS_CLKOUT, 8'h05);
    meas(256);
    `CK("clock out raw", 1'b1, nt inside {[31:33]})
    wb(1, OFS_DIVIDER, 8'h00);
    wb(1, OFS_SWITCH, 8'h07);
    repeat (20) @(posedge i_sys_clk);
    wb(0, OFS_STATUS, 8'h00);
    `CK("slow rc selected", 8'h03, rd)
    // Second reset in mid-run must restore the start-up clock
    i_reset_n <= 1'b0;
    repeat (3) @(posedge i_sys_clk);
    i_reset_n <= 1'b1;
    wb(0, OFS_STATUS, 8'h00);
    `CK("reset again source", 8'h02, rd)
    wb(0, OFS_DIVIDER, 8'h00);
    `CK("reset again divider", 8'h03, rd)
    complete_run();
  end
endmodule : master_clock_controller_test
`default_nettype wire
